// file: pic_irq_chk.sv
`timescale 1ns/10ps
module pic_irq_chk #(
  parameter int MASK_W = 4,
  parameter int LATCH_W = 6,
  parameter int PC_W = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Sequencer side
  input wire logic instrDone,
  input wire logic timerBusy,
  input wire pic_pkg::pic_cmd_t cmd,
  input wire logic [MASK_W-1:0] accIn,
  input wire pic_pkg::pic_frame_t popFrame,
  // Controller outputs
  input wire logic ackBusy,
  input wire logic pushStrobe,
  input wire logic pcLoad,
  input wire logic [PC_W-1:0] pcValue,
  input wire logic flagsLoad,
  input wire logic [3:0] flagsValue,
  input wire logic [MASK_W-1:0] accOut,
  input wire logic accOutValid,
  input wire logic master_irq_enable,
  input wire logic [MASK_W-1:0] source_enable_mask,
  input wire logic [LATCH_W-1:0] request_latch
);
  // Latches that may be taken; the high pin has no mask bit
  wire logic [5:0] allowed = {1'b1, 1'b0, source_enable_mask[2], source_enable_mask[1],
    source_enable_mask[1], source_enable_mask[0]};
  wire logic pend = |(request_latch[5:0] & allowed);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Acceptance is checked only in a quiet cycle, so no command strobe competes with it
  sequence s_accept;
    !ackBusy && master_irq_enable && pend && instrDone && !timerBusy && cmd == '0;
  endsequence
  sequence s_enter;
    pushStrobe && ackBusy && !master_irq_enable;
  endsequence
  property p_accept;
    s_accept |=> s_enter;
  endproperty
  a_accept: assert property (p_accept) else $error("acceptance did not push");
  sequence s_busy8;
    ackBusy [*8];
  endsequence
  property p_len;
    $rose(ackBusy) |-> s_busy8 ##1 s_busy8 ##1 (pcLoad && !ackBusy);
  endproperty
  a_len: assert property (p_len) else $error("acknowledge length wrong");
  property p_vec;
    $fell(ackBusy) |-> pcLoad && flagsLoad && flagsValue[2] &&
      pcValue inside {12'h002, 12'h006, 12'h008, 12'h00A, 12'h00C};
  endproperty
  a_vec: assert property (p_vec) else $error("acknowledge end wrong");
  property p_refuse;
    !master_irq_enable && !ackBusy |=> !pushStrobe;
  endproperty
  a_refuse: assert property (p_refuse) else $error("push while disabled");
  property p_busy;
    timerBusy && !ackBusy |=> !pushStrobe;
  endproperty
  a_busy: assert property (p_busy) else $error("accepted during timer work");
  property p_ret;
    cmd.retFromIrq && !ackBusy |=> pcLoad && master_irq_enable && pcValue == $past(popFrame.pc);
  endproperty
  a_ret: assert property (p_ret) else $error("return wrong");
  property p_swap;
    cmd.swapMask |=> accOutValid && source_enable_mask == $past(accIn) &&
      accOut == $past(source_enable_mask);
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");
  property p_dis;
    cmd.disableClr |=> !master_irq_enable;
  endproperty
  a_dis: assert property (p_dis) else $error("master not cleared");
  property p_keep;
    !ackBusy && cmd == '0 |=> (request_latch & $past(request_latch)) == $past(request_latch);
  endproperty
  a_keep: assert property (p_keep) else $error("latch lost");
  property p_spare;
    request_latch[4] == 1'b0;
  endproperty
  a_spare: assert property (p_spare) else $error("spare latch set");
endmodule // pic_irq_chk

bind pic_irq_controller pic_irq_chk #(.MASK_W(MASK_W), .LATCH_W(LATCH_W), .PC_W(PC_W)) u_chk (.*);

// file: pic_irq_controller.sv
// How it works
// RULE1: Five sources, two pins and three timer events, each with its own latch.
// RULE2: Fixed priority: high pin, timer 1, timer 2, interval tick, low pin.
// RULE3: Acknowledge loads vector 002h, 006h, 008h or 00Ch by source.
// RULE4: Master enable gates every source; zero blocks all acceptance.
// RULE5: Acceptance clears master enable until return or software sets it.
// RULE6: Enable-and-clear sets master enable; disable-and-clear clears it.
// RULE7: Four-bit mask enables each source except the high pin; one enables.
// RULE8: Mask bit 1 covers timer 2 and tick; bit 2 timer 1; bit 0 low pin.
// RULE9: Mask is read and written only by a swap with the accumulator.
// RULE10: Low pin latches its edge even when masked, but is not accepted.
// RULE11: Latch holds until accepted, cleared by instruction, or reset.
// RULE12: Latch instruction field: zero bit clears that latch, one keeps it.
// RULE13: No instruction can set a latch; only source hardware can.
// RULE14: Acknowledge takes two instruction cycles after the instruction ends.
// RULE15: Order: push pc and flags, vector, branch flag, master off, latch clear. Here master off comes with the push, before the vector.
// RULE16: Return pops pc and flags and sets master enable.
// RULE17: Only pc and flags are saved; accumulator left to software.
// RULE18: External latch sets on a falling pin edge, even in port use.
// RULE19: Pin high and low phases last two instruction cycles or more.
// RULE20: High pin has no mask bit; accepted whenever master enable is one.
// RULE21: Reset is held three or more instruction cycles with clock running.
// RULE22: After reset, execution starts at 000h.
// RULE23: Reset: pc 000h, branch flag 1, master 0, mask 0, latches 0, tick 0.
// RULE24: Interval tick vector is taken as 00Ah.
`timescale 1ns/10ps
`include "pic_regs.svh"

module pic_irq_controller #(
  parameter int MASK_W = 4,
  parameter int LATCH_W = 6,
  parameter int PC_W = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // External request pins, asynchronous
  input wire logic ext_request_high_prio,
  input wire logic ext_request_low_prio,
  // Internal request pulses, same clock
  input wire logic timer1_overflow_request,
  input wire logic timer2_overflow_request,
  input wire logic interval_tick_request,
  // Sequencer handshake
  input wire logic instrDone,
  input wire logic timerBusy,
  input wire pic_pkg::pic_cmd_t cmd,
  input wire logic [LATCH_W-1:0] latchField,
  input wire logic [MASK_W-1:0] accIn,
  // Core state to save and to restore
  input wire pic_pkg::pic_frame_t curFrame,
  input wire pic_pkg::pic_frame_t popFrame,
  // Outputs to the core
  output logic ackBusy,
  output logic pushStrobe,
  output pic_pkg::pic_frame_t pushFrame,
  output logic pcLoad,
  output logic [PC_W-1:0] pcValue,
  output logic flagsLoad,
  output logic [3:0] flagsValue,
  output logic [MASK_W-1:0] accOut,
  output logic accOutValid,
  output logic master_irq_enable,
  output logic [MASK_W-1:0] source_enable_mask,
  output logic [LATCH_W-1:0] request_latch
);

  // One acknowledge step lasts one instruction cycle of basic clocks
  // The core sequencer counts the same clocks, so both sides stay in step
  localparam int ACK_CLKS = `PIC_CLKS_PER_ICYC;

  // Accepted source index and vector, shared by selection and sequencing
  function automatic logic [2:0] pickSource(input logic [LATCH_W-1:0] lat,
                                            input logic [MASK_W-1:0] msk);
    // Order of the tests fixes the priority; code 7 means nothing to take
    // Masked latches stay set and simply fall through to the next test
    pickSource = 3'h7;
    if (lat[`PIC_IL_EXT_HI])
      pickSource = 3'(`PIC_IL_EXT_HI); // RULE20
    else if (lat[`PIC_IL_TMR1] && msk[`PIC_EM_TMR1])
      pickSource = 3'(`PIC_IL_TMR1);
    else if (lat[`PIC_IL_TMR2] && msk[`PIC_EM_TMR])
      pickSource = 3'(`PIC_IL_TMR2); // RULE8
    else if (lat[`PIC_IL_TICK] && msk[`PIC_EM_TMR])
      pickSource = 3'(`PIC_IL_TICK);
    else if (lat[`PIC_IL_EXT_LO] && msk[`PIC_EM_EXT_LO])
      pickSource = 3'(`PIC_IL_EXT_LO); // RULE10
  endfunction

  // Entry address of each source code
  function automatic logic [PC_W-1:0] vectorOf(input logic [2:0] src);
    case (src)
      3'(`PIC_IL_EXT_HI): vectorOf = `PIC_VEC_EXT_HI; // RULE3
      3'(`PIC_IL_TMR1): vectorOf = `PIC_VEC_TMR1;
      3'(`PIC_IL_TMR2): vectorOf = `PIC_VEC_TMR2;
      3'(`PIC_IL_TICK): vectorOf = `PIC_VEC_TICK; // RULE24
      default: vectorOf = `PIC_VEC_EXT_LO;
    endcase
  endfunction

  // True on the last basic clock of an instruction cycle
  function automatic logic lastClk(input logic [3:0] c);
    lastClk = (c == 4'(ACK_CLKS - 1));
  endfunction

  // High pin synchroniser; the first stage feeds only the second
  // Stages reset to the idle high level, so leaving reset gives no false edge
  logic [1:0] hiSync_reg;
  logic hiPrev_reg;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hiSync_reg <= 2'h3;
      hiPrev_reg <= 1'b1;
    end
    else
    begin
      hiSync_reg <= {hiSync_reg[0], ext_request_high_prio};
      hiPrev_reg <= hiSync_reg[1];
    end
  end

  // Low pin synchroniser, built like the high one
  logic [1:0] loSync_reg;
  logic loPrev_reg;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      loSync_reg <= 2'h3;
      loPrev_reg <= 1'b1;
    end
    else
    begin
      loSync_reg <= {loSync_reg[0], ext_request_low_prio};
      loPrev_reg <= loSync_reg[1];
    end
  end

  // Falling edges, seen whatever the pin is used for
  // Three clocks of latency, far below one instruction cycle
  logic hiFall, loFall;
  assign hiFall = hiPrev_reg && !hiSync_reg[1]; // RULE18
  assign loFall = loPrev_reg && !loSync_reg[1]; // RULE18

  // Sequencer state
  // The source code is frozen at acceptance, the latch is cleared at the end
  pic_pkg::pic_state_t state_reg, state_next;
  logic [3:0] cnt_reg;
  logic [2:0] src_reg;
  logic [2:0] pending;
  logic accept;
  logic cntEnd;
  logic ackEnd;

  // Highest enabled request, or the empty code when none may be taken
  assign pending = pickSource(request_latch, source_enable_mask);
  assign cntEnd = lastClk(cnt_reg);
  assign ackEnd = (state_reg == pic_pkg::PIC_ACK2) && cntEnd;
  // Acceptance waits for the instruction boundary and any timer work
  assign accept = (state_reg == pic_pkg::PIC_IDLE) && master_irq_enable && // RULE4
                  (pending != 3'h7) && instrDone && !timerBusy; // RULE14

  // Next state: one state per instruction cycle of the acknowledge
  // No exit from the middle, so a cut sequence cannot leave a half frame
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      pic_pkg::PIC_IDLE:
        if (accept)
          state_next = pic_pkg::PIC_ACK1;
      pic_pkg::PIC_ACK1:
        if (cntEnd)
          state_next = pic_pkg::PIC_ACK2;
      pic_pkg::PIC_ACK2:
        if (cntEnd)
          state_next = pic_pkg::PIC_IDLE;
      default: state_next = pic_pkg::PIC_IDLE;
    endcase
  end

  // State register
  // Two instruction cycles, each counted in basic clocks
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_reg <= pic_pkg::PIC_IDLE;
    else
      state_reg <= state_next; // RULE14
  end

  // Basic clocks within the current instruction cycle
  // Held at zero when idle so each sequence starts on a clean count
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cnt_reg <= 4'h0;
    else if (state_reg == pic_pkg::PIC_IDLE || cntEnd)
      cnt_reg <= 4'h0;
    else
      cnt_reg <= cnt_reg + 4'h1;
  end

  // Source captured at acceptance
  // A later, higher request cannot change the vector once the push is out
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      src_reg <= 3'h7;
    else if (accept)
      src_reg <= pending; // RULE2
  end

  // Busy for the whole acknowledge
  // The core holds off its next fetch while this stands
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      ackBusy <= 1'b0;
    else
      ackBusy <= (state_next != pic_pkg::PIC_IDLE);
  end

  // Push first, while pc and flags still hold the interrupted context
  // Only these two are saved; the accumulator is left to software
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pushStrobe <= 1'b0;
      pushFrame <= '0;
    end
    else
    begin
      pushStrobe <= accept; // RULE15
      if (accept)
        pushFrame <= curFrame; // RULE17
    end
  end

  // Vector and flag loads at the end of the second cycle
  // Acknowledge end outranks a return; a return there is lost, so none may land there
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pcLoad <= 1'b0;
      pcValue <= `PIC_VEC_RESET; // RULE22
      flagsLoad <= 1'b0;
      flagsValue <= `PIC_FLAGS_RST; // RULE23
    end
    else
    begin
      pcLoad <= 1'b0;
      flagsLoad <= 1'b0;
      if (ackEnd)
      begin
        pcLoad <= 1'b1;
        pcValue <= vectorOf(src_reg); // RULE15
        flagsLoad <= 1'b1;
        flagsValue <= curFrame.flags | 4'(1 << `PIC_FLAG_BRANCH);
      end
      else if (cmd.retFromIrq)
      begin
        pcLoad <= 1'b1;
        pcValue <= popFrame.pc; // RULE16
        flagsLoad <= 1'b1;
        flagsValue <= popFrame.flags;
      end
    end
  end

  // Master enable; acceptance clears it at once so no second request slips in
  // A same-cycle enable command loses to acceptance, so software
  // re-enabling nesting must do so inside the service routine
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      master_irq_enable <= 1'b0; // RULE23
    else if (accept)
      master_irq_enable <= 1'b0; // RULE5
    else if (cmd.retFromIrq || cmd.enableClr)
      master_irq_enable <= 1'b1; // RULE6
    else if (cmd.disableClr)
      master_irq_enable <= 1'b0;
  end

  // Enable mask, reachable only by the swap
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      source_enable_mask <= `PIC_MASK_RST;
    else if (cmd.swapMask)
      source_enable_mask <= accIn; // RULE9
  end

  // Old mask returned to the accumulator in the same swap
  // Taken before the write lands, so the two halves of the exchange never mix
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      accOut <= `PIC_MASK_RST;
      accOutValid <= 1'b0;
    end
    else
    begin
      accOutValid <= cmd.swapMask;
      if (cmd.swapMask)
        accOut <= source_enable_mask; // RULE7
    end
  end

  // Request latches; a new request beats a clear in the same cycle
  // Losing a request is worse than servicing one twice, hence set wins
  // Instructions only ever narrow the keep mask, they never add a bit
  // The acknowledge clear touches only the source that was frozen
  logic [LATCH_W-1:0] setVec, keepVec;
  always_comb
  begin
    setVec = '0;
    setVec[`PIC_IL_EXT_HI] = hiFall;
    setVec[`PIC_IL_TMR1] = timer1_overflow_request;
    setVec[`PIC_IL_TMR2] = timer2_overflow_request;
    setVec[`PIC_IL_TICK] = interval_tick_request;
    setVec[`PIC_IL_EXT_LO] = loFall; // RULE1
    keepVec = '1;
    if (cmd.enableClr || cmd.disableClr || cmd.latchClr)
      keepVec = latchField; // RULE12
    if (ackEnd)
      keepVec[src_reg] = 1'b0; // RULE15
  end

  // Spare latch position has no source and stays clear
  // Forcing it low keeps a stray field bit from ever showing there
  // All six bits update together, one flop each
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      request_latch <= `PIC_LATCH_RST; // RULE23
    else
      request_latch <= ((request_latch & keepVec) | setVec) & // RULE11 RULE13
                       ~(LATCH_W'(1) << `PIC_IL_SPARE);
  end

endmodule // pic_irq_controller

// file: pic_pkg.sv
package pic_pkg;

  // Acknowledge sequencer states
  typedef enum logic [1:0] {PIC_IDLE, PIC_ACK1, PIC_ACK2} pic_state_t;

  // Instruction strobes from the sequencer
  typedef struct packed {
    logic enableClr;
    logic disableClr;
    logic latchClr;
    logic swapMask;
    logic retFromIrq;
  } pic_cmd_t;

  // State pushed on acknowledge
  typedef struct packed {
    logic [11:0] pc;
    logic [3:0] flags;
  } pic_frame_t;

endpackage

// file: pic_regs.svh
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH

// Entry addresses, 12-bit program counter
`define PIC_VEC_RESET 12'h000
`define PIC_VEC_EXT_HI 12'h002
`define PIC_VEC_TMR1 12'h006
`define PIC_VEC_TMR2 12'h008
`define PIC_VEC_TICK 12'h00A
`define PIC_VEC_EXT_LO 12'h00C

// Request latch bit positions
`define PIC_IL_EXT_LO 0
`define PIC_IL_TICK 1
`define PIC_IL_TMR2 2
`define PIC_IL_TMR1 3
`define PIC_IL_SPARE 4
`define PIC_IL_EXT_HI 5

// Enable mask bit positions
`define PIC_EM_EXT_LO 0
`define PIC_EM_TMR 1
`define PIC_EM_TMR1 2

// Reset values
`define PIC_MASK_RST 4'h0
`define PIC_LATCH_RST 6'h00
`define PIC_FLAGS_RST 4'h4

// Branch flag position inside the flag nibble
`define PIC_FLAG_BRANCH 2

// Basic clocks per instruction cycle, acknowledge length in instruction cycles
`define PIC_CLKS_PER_ICYC 8
`define PIC_ACK_ICYC 2

`endif

// file: pic_seq_model.sv
`timescale 1ns/10ps
module pic_seq_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // From the controller
  input wire logic ackBusy,
  input wire logic pushStrobe,
  input wire pic_pkg::pic_frame_t pushFrame,
  input wire logic pcLoad,
  input wire logic [11:0] pcValue,
  input wire logic flagsLoad,
  input wire logic [3:0] flagsValue,
  // To the controller
  output logic instrDone,
  output pic_pkg::pic_frame_t curFrame,
  output pic_pkg::pic_frame_t popFrame
);
  pic_pkg::pic_frame_t stack [8];
  logic [2:0] cnt_reg, sp_reg;
  logic busy_reg;

  // Eight deep stack; deeper nesting wraps and overwrites the oldest frame
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_reg <= 3'h0;
      sp_reg <= 3'h0;
      busy_reg <= 1'b0;
      curFrame <= {12'h000, 4'h4};
    end
    else
    begin
      cnt_reg <= cnt_reg + 3'h1;
      busy_reg <= ackBusy;
      if (cnt_reg == 3'h7)
        curFrame.pc <= curFrame.pc + 12'h001;
      if (pushStrobe)
        stack[sp_reg] <= pushFrame;
      if (pushStrobe)
        sp_reg <= sp_reg + 3'h1;
      if (pcLoad)
        curFrame.pc <= pcValue;
      if (flagsLoad)
        curFrame.flags <= flagsValue;
      // A load outside acknowledge is a return and pops the frame
      if (pcLoad && !busy_reg)
        sp_reg <= sp_reg - 3'h1;
    end
  end

  // Boundary once per eight basic clocks
  assign instrDone = (cnt_reg == 3'h7);
  assign popFrame = stack[sp_reg - 3'h1];
endmodule // pic_seq_model

// file: testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0, sys_rst = 1'b1;
  logic ext_request_high_prio = 1'b1, ext_request_low_prio = 1'b1;
  logic timer1_overflow_request = 1'b0, timer2_overflow_request = 1'b0;
  logic interval_tick_request = 1'b0, timerBusy = 1'b0, instrDone;
  pic_pkg::pic_cmd_t cmd = '0;
  logic [5:0] latchField = 6'h3F, request_latch;
  logic [3:0] accIn = 4'h0, flagsValue, accOut, source_enable_mask;
  pic_pkg::pic_frame_t curFrame, popFrame, pushFrame;
  logic ackBusy, pushStrobe, pcLoad, flagsLoad, accOutValid, master_irq_enable;
  logic [11:0] pcValue;
  int n_errors = 0, n_tests = 0;
  logic [11:0] vec [5] = '{12'h002, 12'h006, 12'h008, 12'h00A, 12'h00C};
  logic [5:0] left [5] = '{6'h0F, 6'h07, 6'h03, 6'h01, 6'h00};

  // Clock and the two ends
  always #2.5 clk = ~clk;
  pic_irq_controller DUT (.*);
  pic_seq_model u_seq (.*);

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Inputs always move 1 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic issue(input logic [4:0] c, input logic [5:0] f, input logic [3:0] a);
    cmd = c;
    latchField = f;
    accIn = a;
    step(1);
    cmd = '0;
  endtask
  // Each phase lasts two instruction cycles so the synchroniser sees it
  task automatic pin_fall(input logic hi);
    if (hi)
      ext_request_high_prio = 1'b0;
    else
      ext_request_low_prio = 1'b0;
    step(16);
    ext_request_high_prio = 1'b1;
    ext_request_low_prio = 1'b1;
    step(16);
  endtask
  task automatic wait_load;
    int k;
    step(1);
    for (k = 0; k < 100 && pcLoad !== 1'b1; k++)
      step(1);
    chk("pcLoad", pcLoad, 1'b1);
  endtask

  task automatic t_reset;
    chk("state", {master_irq_enable, source_enable_mask, request_latch}, 11'h000);
    chk("flags", flagsValue, 4'h4);
    chk("pc", pcValue, 12'h000);
    $display("t_reset done");
  endtask
  task automatic t_prio;
    int i;
    issue(5'h02, 6'h3F, 4'hF);
    chk("old mask", accOut, 4'h0);
    timer1_overflow_request = 1'b1;
    timer2_overflow_request = 1'b1;
    interval_tick_request = 1'b1;
    step(1);
    {timer1_overflow_request, timer2_overflow_request, interval_tick_request} = 3'h0;
    pin_fall(1'b1);
    pin_fall(1'b0);
    chk("latch", request_latch, 6'h2F);
    issue(5'h10, 6'h3F, 4'hF);
    for (i = 0; i < 5; i++)
    begin
      wait_load;
      chk("vector", pcValue, vec[i]);
      chk("branch", flagsValue[2], 1'b1);
      chk("master", master_irq_enable, 1'b0);
      chk("left", request_latch, left[i]);
      issue(5'h01, 6'h3F, 4'hF);
      chk("master ret", master_irq_enable, 1'b1);
      chk("ret pc", pcValue, pushFrame.pc);
      chk("ret flags", flagsValue, pushFrame.flags);
    end
    $display("t_prio done");
  endtask
  task automatic t_mask;
    issue(5'h02, 6'h3F, 4'hE);
    pin_fall(1'b0);
    chk("low held", {master_irq_enable, request_latch}, 7'h41);
    issue(5'h04, 6'h3F, 4'hE);
    chk("keep", request_latch, 6'h01);
    step(1);
    issue(5'h04, 6'h3E, 4'hE);
    chk("clear", request_latch, 6'h00);
    step(1);
    issue(5'h08, 6'h3F, 4'h0);
    chk("disabled", master_irq_enable, 1'b0);
    step(1);
    issue(5'h02, 6'h3F, 4'h0);
    pin_fall(1'b1);
    chk("high held", request_latch, 6'h20);
    issue(5'h10, 6'h3F, 4'h0);
    wait_load;
    chk("high vec", pcValue, 12'h002);
    issue(5'h01, 6'h3F, 4'h0);
    $display("t_mask done");
  endtask
  // Timer work holds off acceptance; a long reset then clears all state
  task automatic t_busy;
    timerBusy = 1'b1;
    issue(5'h02, 6'h3F, 4'hF);
    step(1);
    issue(5'h10, 6'h3F, 4'hF);
    pin_fall(1'b1);
    chk("busy held", {master_irq_enable, ackBusy, request_latch}, 8'hA0);
    timerBusy = 1'b0;
    wait_load;
    chk("busy vec", pcValue, 12'h002);
    issue(5'h01, 6'h3F, 4'hF);
    step(1);
    issue(5'h08, 6'h3F, 4'hF);
    pin_fall(1'b0);
    chk("pre reset", {master_irq_enable, request_latch}, 7'h01);
    sys_rst = 1'b1;
    step(24);
    sys_rst = 1'b0;
    step(1);
    t_reset;
    $display("t_busy done");
  endtask

  task automatic end_sim;
    $display("Checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence, reset held for two clocks
  initial
  begin
    step(2);
    sys_rst = 1'b0;
    step(1);
    t_reset;
    t_prio;
    t_mask;
    t_busy;
    end_sim;
  end
  // Run needs about 400 cycles; stop a hang well beyond that
  initial
  begin
    #40000;
    n_errors++;
    end_sim;
  end
endmodule // testbench
